// ### shared/pcg_pkg.sv
// constants for the grant-time and power-capability configuration fields
// assumes the host reaches them by dword-indexed configuration cycles
package pcg_pkg;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int          CLK_PERIOD_NS     = 5;    // system clock period
  localparam int          BURST_UNIT_NS     = 250;  // one grant unit
  localparam int          BURST_CYC_W       = 14;   // holds 255 units
  // cycles in one grant unit, rounded down (a duration the host honours)
  localparam logic [13:0] BURST_UNIT_CYCLES =
    14'(BURST_UNIT_NS / CLK_PERIOD_NS);

  // ==========================================================================
  // configuration map: byte offsets and dword indices
  // ==========================================================================
  localparam logic [7:0] OFS_MIN_GRANT  = 8'h3e;  // byte wide
  localparam logic [7:0] OFS_CAP_ID     = 8'h50;  // capability id byte
  localparam logic [7:0] OFS_CHAIN_LINK = 8'h51;  // next capability
  localparam logic [7:0] OFS_POWER_CAP  = 8'h52;  // word wide
  localparam logic [5:0] DW_GRANT       = 6'(OFS_MIN_GRANT >> 2);
  localparam logic [5:0] DW_POWER       = 6'(OFS_POWER_CAP >> 2);
  localparam int         LANE_GRANT     = 2;      // byte lane of 0x3e
  localparam int         LANE_POWER     = 2;      // low lane of 0x52

  // ==========================================================================
  // reset and constant values
  // ==========================================================================
  localparam logic [7:0]  MIN_GRANT_RST  = 8'h0a;
  localparam logic [7:0]  CHAIN_LINK_END = 8'h00; // nothing follows
  localparam logic [7:0]  CAP_ID_POWER   = 8'h01;
  localparam logic [15:0] POWER_CAP_RST  = 16'h7601;
  localparam logic [2:0]  PM_VERSION     = 3'h2;
  localparam logic        WAKE_D0_FIXED  = 1'b0;
  localparam logic        WAKE_D3H_FIXED = 1'b1;
  // loaded power bits {wake d3cold, wake d2, wake d1, d2 ok, d1 ok}
  localparam logic [4:0]  PM_LOAD_RST    = {POWER_CAP_RST[15],
    POWER_CAP_RST[13], POWER_CAP_RST[12], POWER_CAP_RST[10],
    POWER_CAP_RST[9]};

  // ==========================================================================
  // eeprom configuration word layout
  // ==========================================================================
  localparam int EE_GRANT_LO = 0;   // bits 7:0 grant count
  localparam int EE_D1_OK    = 8;
  localparam int EE_D2_OK    = 9;
  localparam int EE_WAKE_D1  = 10;
  localparam int EE_WAKE_D2  = 11;
  localparam int EE_WAKE_D3C = 12;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef enum logic [1:0] {
    INIT_WAIT = 2'b00,  // defaults shown, waiting for eeprom
    INIT_LOAD = 2'b01,  // copy captured word into fields
    INIT_DONE = 2'b10   // auto-initialisation finished
  } pcg_init_state_type;

  typedef enum logic [2:0] {
    PS_D0     = 3'b000,
    PS_D1     = 3'b001,
    PS_D2     = 3'b010,
    PS_D3HOT  = 3'b011,
    PS_D3COLD = 3'b100
  } pcg_power_state_type;

endpackage : pcg_pkg

// ### design/pcg_load_field.sv
// one read-only field that holds its reset value until a load strobe
// assumes the load strobe is synchronous to the system clock
`timescale 1ns/100ps

module pcg_load_field #(
  parameter int          WIDTH = 8,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             i_clk_sys,  // system clock
  input  wire logic             i_rst,      // async reset, high
  input  wire logic             i_load,     // capture strobe
  input  wire logic [WIDTH-1:0] i_data,     // value to capture
  output logic      [WIDTH-1:0] o_q         // held field value
);

  // ==========================================================================
  // storage
  // ==========================================================================
  logic [WIDTH-1:0] field_q;  // current field value
  logic [WIDTH-1:0] field_d;  // next field value

  // only the load strobe changes the field; host writes never reach it
  assign field_d = i_load ? i_data : field_q;
  assign o_q     = field_q;

  // register with constant reset value
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      field_q <= RST_VAL;
    end else begin
      field_q <= field_d;
    end
  end

endmodule : pcg_load_field

// ### design/pcg_cfg_fields.sv
// grant-time byte, capability link and power capability word
// assumes one configuration access per request pulse, dword indexed
//
// Contract
// - grant byte counts 250 ns burst units
// - grant read-only, loaded from eeprom word
// - grant byte wide, default 0x0a
// - chain link reads 0x00, list ends
// - version bits 2:0 always read 0x2
// - bits 9,10 report d1,d2 support, loaded
// - bits 15:11 wake mask d0 to d3cold
// - wake only from states with mask set
// - mask bits 12,13,15 loaded, others fixed
// - power word at 0x52, default reads 0x7602
`timescale 1ns/100ps

module pcg_cfg_fields
  import pcg_pkg::*;
#(
  parameter int GRANT_W = 8    // grant byte width
) (
  input  wire logic        i_clk_sys,            // system clock
  input  wire logic        i_rst,                // async reset, high
  input  wire logic        i_cfg_req,            // access strobe
  input  wire logic        i_cfg_write,          // 1 write, 0 read
  input  wire logic [5:0]  i_cfg_dw_addr,        // dword index
  input  wire logic [3:0]  i_cfg_be,             // byte enables
  input  wire logic [31:0] i_cfg_wdata,          // write data
  input  wire logic        i_eeprom_valid,       // word present
  input  wire logic [15:0] i_eeprom_config_word, // eeprom field
  input  wire logic [2:0]  i_power_state,        // current d-state
  input  wire logic        i_pme_event,          // wake request
  input  wire logic        i_wake_clear,         // drop wake
  output logic             o_cfg_ack,            // access done
  output logic [31:0]      o_cfg_rdata,          // read data
  output logic             o_autoinit_done,      // fields loaded
  output logic [13:0]      o_burst_grant_cycles, // grant in clocks
  output logic             o_wake                // wake output
);

  // ==========================================================================
  // auto-initialisation sequencer
  // ==========================================================================
  pcg_init_state_type state_q;     // sequencer state
  pcg_init_state_type state_d;     // next state
  logic [15:0]        ee_word_q;   // captured eeprom word
  logic [15:0]        ee_word_d;   // next captured word
  logic               load_fields; // copy word into fields

  // capture on arrival, copy one cycle later so the word is stable
  always_comb begin
    state_d = state_q;
    case (state_q)
      INIT_WAIT: begin
        if (i_eeprom_valid) begin
          state_d = INIT_LOAD;
        end
      end
      INIT_LOAD: begin
        state_d = INIT_DONE;
      end
      INIT_DONE: begin
        state_d = INIT_DONE;  // left only by reset
      end
      default: begin
        state_d = INIT_WAIT;
      end
    endcase
  end

  assign ee_word_d   = (state_q == INIT_WAIT && i_eeprom_valid) ?
                       i_eeprom_config_word : ee_word_q;
  assign load_fields = (state_q == INIT_LOAD);

  // sequencer registers
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_q   <= INIT_WAIT;
      ee_word_q <= 16'h0000;
    end else begin
      state_q   <= state_d;
      ee_word_q <= ee_word_d;
    end
  end

  // ==========================================================================
  // loaded fields
  // ==========================================================================
  logic [GRANT_W-1:0] min_grant_q;  // grant count in 250 ns units
  logic [4:0]         pm_load_q;    // {w d3c, w d2, w d1, d2, d1}
  logic [4:0]         pm_load_in;   // eeprom bits for pm_load_q

  assign pm_load_in = {ee_word_q[EE_WAKE_D3C], ee_word_q[EE_WAKE_D2],
                       ee_word_q[EE_WAKE_D1], ee_word_q[EE_D2_OK],
                       ee_word_q[EE_D1_OK]};

  pcg_load_field #(
    .WIDTH   (GRANT_W),
    .RST_VAL (MIN_GRANT_RST)
  ) u_grant (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_load    (load_fields),
    .i_data    (ee_word_q[EE_GRANT_LO +: GRANT_W]),
    .o_q       (min_grant_q)
  );

  pcg_load_field #(
    .WIDTH   (5),
    .RST_VAL (PM_LOAD_RST)
  ) u_power (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_load    (load_fields),
    .i_data    (pm_load_in),
    .o_q       (pm_load_q)
  );

  // ==========================================================================
  // power capability word
  // ==========================================================================
  logic [4:0]  wake_mask;   // bit n allows wake from state n
  logic [15:0] power_word;  // word as the host sees it

  assign wake_mask = {pm_load_q[4], WAKE_D3H_FIXED, pm_load_q[3],
                      pm_load_q[2], WAKE_D0_FIXED};

  assign power_word = {wake_mask, pm_load_q[1], pm_load_q[0],
                       6'h00, PM_VERSION};

  // ==========================================================================
  // configuration read decode
  // ==========================================================================
  logic        hit_grant;  // dword holding the grant byte
  logic        hit_power;  // dword holding the capability
  logic [31:0] rd_dword;   // unmasked read value
  logic [31:0] be_mask;    // byte enables spread to bits
  logic [31:0] rdata_d;    // next read data

  assign hit_grant = (i_cfg_dw_addr == DW_GRANT);
  assign hit_power = (i_cfg_dw_addr == DW_POWER);
  assign be_mask   = {{8{i_cfg_be[3]}}, {8{i_cfg_be[2]}},
                      {8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};

  // lane placement; unmapped dwords read zero
  assign rd_dword = hit_grant ? {8'h00, min_grant_q, 16'h0000} :
                    hit_power ? {power_word, CHAIN_LINK_END,
                                 CAP_ID_POWER} :
                    32'h0000_0000;

  assign rdata_d = (i_cfg_req && !i_cfg_write) ?
                   (rd_dword & be_mask) : 32'h0000_0000;

  // write data is deliberately unused: every field here is read-only
  logic unused_wdata;
  assign unused_wdata = ^i_cfg_wdata;

  // answer every access one cycle after its request
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_cfg_ack   <= 1'b0;
      o_cfg_rdata <= 32'h0000_0000;
    end else begin
      o_cfg_ack   <= i_cfg_req;
      o_cfg_rdata <= rdata_d;
    end
  end

  // ==========================================================================
  // grant length in clocks and status
  // ==========================================================================
  logic [13:0] burst_cycles_d;  // grant count times unit cycles

  assign burst_cycles_d = 14'(min_grant_q) * BURST_UNIT_CYCLES;

  // registered so the product path stays off the outputs
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_burst_grant_cycles <= 14'h0000;
      o_autoinit_done      <= 1'b0;
    end else begin
      o_burst_grant_cycles <= burst_cycles_d;
      o_autoinit_done      <= (state_q == INIT_DONE);
    end
  end

  // ==========================================================================
  // wake output
  // ==========================================================================
  logic state_ok;  // current state may raise a wake
  logic wake_set;  // qualified wake request
  logic wake_d;    // next wake level

  // undefined state codes never wake
  assign state_ok = (i_power_state <= 3'(PS_D3COLD)) &&
                    wake_mask[i_power_state];
  assign wake_set = i_pme_event && state_ok;
  // a request in the clearing cycle wins so no event is lost
  assign wake_d   = wake_set || (o_wake && !i_wake_clear);

  // sticky wake level
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_wake <= 1'b0;
    end else begin
      o_wake <= wake_d;
    end
  end

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  // the product register is still cleared on the edge that ends reset
  burst_cycles_a: assert property (
    !$past(i_rst) |-> o_burst_grant_cycles ==
        14'($past(min_grant_q)) * BURST_UNIT_CYCLES)
    else $error("grant cycles do not match grant units");

  grant_load_a: assert property (
    load_fields |=> min_grant_q == $past(ee_word_q[7:0]))
    else $error("grant byte not loaded from eeprom word");

  grant_default_a: assert property (
    (state_q == INIT_WAIT) |-> min_grant_q == MIN_GRANT_RST)
    else $error("grant byte lost its default before load");

  chain_end_a: assert property (
    (i_cfg_req && !i_cfg_write && hit_power && i_cfg_be[1])
      |=> o_cfg_ack && o_cfg_rdata[15:8] == CHAIN_LINK_END)
    else $error("chain link not zero");

  version_read_a: assert property (
    (i_cfg_req && !i_cfg_write && hit_power && i_cfg_be[2])
      |=> o_cfg_rdata[18:16] == PM_VERSION)
    else $error("version field wrong");

  reserved_zero_a: assert property (
    (i_cfg_req && hit_power) |=> o_cfg_rdata[24:19] == 6'h00)
    else $error("reserved capability bits not zero");

  support_bits_a: assert property (
    (i_cfg_req && !i_cfg_write && hit_power && i_cfg_be[3])
      |=> o_cfg_rdata[26:25] == $past(pm_load_q[1:0]))
    else $error("d1 or d2 support bit wrong");

  mask_bits_a: assert property (
    (i_cfg_req && !i_cfg_write && hit_power && i_cfg_be[3])
      |=> o_cfg_rdata[31:27] == {$past(pm_load_q[4]), WAKE_D3H_FIXED,
          $past(pm_load_q[3]), $past(pm_load_q[2]), WAKE_D0_FIXED})
    else $error("wake mask bits misplaced");

  wake_gate_a: assert property (
    $rose(o_wake) |-> $past(i_pme_event) &&
                      $past(wake_mask[i_power_state]))
    else $error("wake raised from a masked state");

  mask_load_a: assert property (
    load_fields |=> pm_load_q[4:2] ==
      {$past(ee_word_q[EE_WAKE_D3C]), $past(ee_word_q[EE_WAKE_D2]),
       $past(ee_word_q[EE_WAKE_D1])})
    else $error("loaded wake mask bits wrong");

  default_word_a: assert property (
    (state_q == INIT_WAIT && i_cfg_req && !i_cfg_write && hit_power &&
     i_cfg_be[3] && i_cfg_be[2])
      |=> o_cfg_rdata[31:19] == POWER_CAP_RST[15:3])
    else $error("power word default wrong");

  write_ignored_a: assert property (
    (i_cfg_req && i_cfg_write && !load_fields)
      |=> o_cfg_ack && o_cfg_rdata == 32'h0000_0000 &&
          $stable(min_grant_q) && $stable(pm_load_q))
    else $error("write changed a read-only field");

  // every access, read or write, is answered in the next cycle
  access_ack_a: assert property (
    i_cfg_req |=> o_cfg_ack)
    else $error("access not acknowledged");

  // no answer and no data without a request just before
  stray_ack_a: assert property (
    !i_cfg_req |=> !o_cfg_ack && o_cfg_rdata == 32'h0000_0000)
    else $error("acknowledge without a request");

  // a qualified event raises wake even against a clear
  wake_wins_a: assert property (
    wake_set |=> o_wake)
    else $error("qualified wake request lost");

  load_seen_c:   cover property (state_q == INIT_LOAD);
  power_read_c:  cover property (i_cfg_req && !i_cfg_write && hit_power);
  wake_raised_c: cover property (wake_set && !o_wake);
  wake_clear_c:  cover property (o_wake && i_wake_clear && !wake_set);
  // an event in a state whose mask bit is clear
  masked_evt_c:  cover property (i_pme_event && !state_ok);

endmodule : pcg_cfg_fields

// ### verif/pcg_host_model.sv
// host model that issues configuration cycles to the field block
// assumes the block answers every request with an ack one clock later
`timescale 1ns/100ps

module pcg_host_model (
  input  wire logic        i_clk_sys,     // system clock
  input  wire logic        i_cfg_ack,     // access done
  input  wire logic [31:0] i_cfg_rdata,   // read data
  output logic             o_cfg_req,     // access strobe
  output logic             o_cfg_write,   // 1 write, 0 read
  output logic [5:0]       o_cfg_dw_addr, // dword index
  output logic [3:0]       o_cfg_be,      // byte enables
  output logic [31:0]      o_cfg_wdata    // write data
);
  // ==========================================================================
  // idle bus at time zero
  // ==========================================================================
  initial begin
    o_cfg_req     = 1'b0;
    o_cfg_write   = 1'b0;
    o_cfg_dw_addr = 6'h00;
    o_cfg_be      = 4'h0;
    o_cfg_wdata   = 32'h0;
  end

  // ==========================================================================
  // one access: a single request pulse, answer taken in the ack cycle
  // ==========================================================================
  task automatic cfg_access(input logic wr, input logic [5:0] dw,
                            input logic [3:0] be, input logic [31:0] wd,
                            output logic [31:0] rd, output logic ack);
    @(posedge i_clk_sys);
    o_cfg_req     <= 1'b1;
    o_cfg_write   <= wr;
    o_cfg_dw_addr <= dw;
    o_cfg_be      <= be;
    o_cfg_wdata   <= wd & ~32'h01f8_0000;
    @(posedge i_clk_sys);
    // strobe is one cycle wide; qualifiers stay until the ack edge
    o_cfg_req     <= 1'b0;
    @(posedge i_clk_sys);
    // answer taken at the edge where ack is sampled high
    rd  = i_cfg_rdata;
    ack = i_cfg_ack;
    // released qualifiers flip so stale values cannot pass for a match
    o_cfg_write   <= ~wr;
    o_cfg_dw_addr <= ~dw;
    o_cfg_be      <= ~be;
    o_cfg_wdata   <= ~wd;
  endtask : cfg_access
endmodule : pcg_host_model

// ### verif/pci_cfg_grant_and_pm_capability_test.sv
// self-checking bench for the grant and power capability fields
// assumes the host model above and bench-driven eeprom and wake inputs
`timescale 1ns/100ps

module pci_cfg_grant_and_pm_capability_test;
  import pcg_pkg::*;
  logic        i_clk_sys, i_rst, i_eeprom_valid, i_pme_event, i_wake_clear;
  logic [15:0] i_eeprom_config_word; // eeprom field
  logic [2:0]  i_power_state;        // current d-state
  logic        cfg_req, cfg_write, o_cfg_ack, o_autoinit_done, o_wake;
  logic [5:0]  cfg_dw;               // dword index
  logic [3:0]  cfg_be;               // byte enables
  logic [31:0] cfg_wdata, o_cfg_rdata;
  logic [13:0] o_burst_grant_cycles; // grant in clocks
  int          error_cnt, checks_done, cyc;

  pcg_cfg_fields pcg_cfg_fields_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_cfg_req(cfg_req), .i_cfg_write(cfg_write), .i_cfg_dw_addr(cfg_dw),
    .i_cfg_be(cfg_be), .i_cfg_wdata(cfg_wdata),
    .i_eeprom_valid(i_eeprom_valid),
    .i_eeprom_config_word(i_eeprom_config_word),
    .i_power_state(i_power_state), .i_pme_event(i_pme_event),
    .i_wake_clear(i_wake_clear), .o_cfg_ack(o_cfg_ack),
    .o_cfg_rdata(o_cfg_rdata), .o_autoinit_done(o_autoinit_done),
    .o_burst_grant_cycles(o_burst_grant_cycles), .o_wake(o_wake));

  pcg_host_model pcg_host_model_i (.i_clk_sys(i_clk_sys),
    .i_cfg_ack(o_cfg_ack), .i_cfg_rdata(o_cfg_rdata), .o_cfg_req(cfg_req),
    .o_cfg_write(cfg_write), .o_cfg_dw_addr(cfg_dw), .o_cfg_be(cfg_be),
    .o_cfg_wdata(cfg_wdata));

  // ==========================================================================
  // clock, and a cycle ceiling well above the ~120 cycles the tests need
  // ==========================================================================
  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt = error_cnt + 1;
      test_done();
    end
  end

  // ==========================================================================
  // comparison, verdict and access helpers
  // ==========================================================================
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done();
    if (error_cnt == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  task automatic rd(input logic [5:0] dw, input logic [3:0] be,
                    input logic [31:0] exp);
    logic [31:0] d;
    logic        a;
    pcg_host_model_i.cfg_access(1'b0, dw, be, 32'h0, d, a);
    check("read ack", {31'h0, a}, 32'h1);
    check("read data", d, exp);
  endtask : rd

  task automatic wr(input logic [5:0] dw, input logic [31:0] wd);
    logic [31:0] d;
    logic        a;
    pcg_host_model_i.cfg_access(1'b1, dw, 4'hf, wd, d, a);
    check("write ack", {31'h0, a}, 32'h1);
    check("write data", d, 32'h0);
  endtask : wr

  // wake attempt in one state; mask bit gives the expected outcome
  task automatic wake_try(input logic [2:0] st, input logic exp);
    @(posedge i_clk_sys);
    i_power_state <= st;
    i_pme_event   <= 1'b1;
    @(posedge i_clk_sys);
    i_pme_event   <= 1'b0;
    @(negedge i_clk_sys);
    check("wake set", {31'h0, o_wake}, {31'h0, exp});
    @(posedge i_clk_sys);
    i_wake_clear  <= 1'b1;
    @(posedge i_clk_sys);
    i_wake_clear  <= 1'b0;
    @(negedge i_clk_sys);
    check("wake clear", {31'h0, o_wake}, 32'h0);
  endtask : wake_try

  task automatic ee_load(input logic [15:0] w);
    @(posedge i_clk_sys);
    i_eeprom_valid       <= 1'b1;
    i_eeprom_config_word <= w;
    @(posedge i_clk_sys);
    i_eeprom_valid       <= 1'b0;
    i_eeprom_config_word <= ~w;
    repeat (3) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
  endtask : ee_load

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    logic [7:0] mask;
    error_cnt = 0;
    checks_done = 0;
    cyc = 0;
    i_rst = 1'b1;
    i_eeprom_valid = 1'b0;
    i_eeprom_config_word = 16'h0;
    i_power_state = 3'h0;
    i_pme_event = 1'b0;
    i_wake_clear = 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    // defaults before any load; lanes off read zero
    // cap id in lane 0, chain link in lane 1, power word above
    rd(DW_POWER, 4'hf, 32'h7602_0001);
    rd(DW_POWER, 4'hc, 32'h7602_0000);
    rd(DW_GRANT, 4'hf, 32'h000a_0000);
    rd(6'h00, 4'hf, 32'h0);
    check("grant cycles", {18'h0, o_burst_grant_cycles},
          32'(MIN_GRANT_RST) * (BURST_UNIT_NS / CLK_PERIOD_NS));
    // writes complete but leave every field alone
    wr(DW_GRANT, 32'hffff_ffff);
    wr(DW_POWER, 32'hffff_ffff);
    rd(DW_POWER, 4'hf, 32'h7602_0001);
    rd(DW_GRANT, 4'hf, 32'h000a_0000);
    // default mask: d1, d2 and d3hot may wake, others never
    mask = 8'b0000_1110;
    for (int s = 0; s < 8; s++) wake_try(3'(s), mask[s]);
    // grant 0x20, d1 ok, wake from d3cold only among loaded bits
    ee_load(16'h1120);
    check("init done", {31'h0, o_autoinit_done}, 32'h1);
    rd(DW_POWER, 4'hf, 32'hc202_0001);
    rd(DW_GRANT, 4'hf, 32'h0020_0000);
    check("grant cycles", {18'h0, o_burst_grant_cycles},
          32'h20 * (BURST_UNIT_NS / CLK_PERIOD_NS));
    // a second load after initialisation is ignored
    ee_load(16'h0e55);
    rd(DW_GRANT, 4'hf, 32'h0020_0000);
    rd(DW_POWER, 4'hf, 32'hc202_0001);
    mask = 8'b0001_1000;
    for (int s = 0; s < 8; s++) wake_try(3'(s), mask[s]);
    // mid-run reset brings the default grant back
    @(posedge i_clk_sys);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    rd(DW_GRANT, 4'hf, 32'h000a_0000);
    test_done();
  end
endmodule : pci_cfg_grant_and_pm_capability_test
